// ### design/trcfg_attr_if.sv
// bus attribute hand-off between the register block and the attribute mapper
interface trcfg_attr_if;
    logic [7:0] attr;
    logic [1:0] share;
    logic [3:0] awcache;
    logic [3:0] arcache;
    logic [1:0] share_out;
    logic [7:0] attr_rb;

    modport regs (output attr, output share, input awcache, input arcache,
        input share_out, input attr_rb);
    modport map (input attr, input share, output awcache, output arcache,
        output share_out, output attr_rb);
endinterface : trcfg_attr_if

// ### design/trcfg_attr_map.sv
// legalises the buffer memory attribute and shareability into bus cache codes
module trcfg_attr_map #(
    parameter bit BUS_AXI4 = 1'b0,
    parameter bit HAS_SWFIFO = 1'b0
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // attribute hand-off
    trcfg_attr_if.map attr_if
);

    // =====================================================================
    // encoding checks, one per bus flavour
    function automatic logic trcfg_legal(input logic [7:0] a);
        logic ok;
        ok = 1'b0;
        if (!BUS_AXI4) begin
            ok = (a[7:4] == 4'h0) && (a[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h6,
                4'h7, 4'ha, 4'hb, 4'he, 4'hf});
        end else if (!HAS_SWFIFO) begin
            ok = (a[7:4] == 4'h0) && (a[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h6,
                4'h7, 4'he, 4'hf});
        end else begin
            ok = a inside {8'h00, 8'h11, 8'h22, 8'h33, 8'ha6, 8'hae, 8'hb7, 8'hbf,
                8'he6, 8'hee, 8'hf7, 8'hff};
        end
        return ok;
    endfunction : trcfg_legal

    logic [7:0] eff_attr;
    logic [1:0] eff_share;
    logic [15:0] q;
    logic [15:0] next_q;

    // reserved codes fall back to the strongest ordering so no bus cycle is ever invalid
    always_comb begin
        eff_attr = trcfg_legal(attr_if.attr) ? attr_if.attr : trcfg_pkg::ATTR_SAFE;
        eff_share = (attr_if.share == trcfg_pkg::SHARE_RESERVED) ?
            trcfg_pkg::SHARE_NONE : attr_if.share;
        next_q = {eff_attr, eff_share, 2'h0, eff_attr[3:0]};
        if (BUS_AXI4 && HAS_SWFIFO) begin
            next_q[3:0] = eff_attr[7:4]; // separate read nibble
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= 16'h0000;
        end else begin
            q <= next_q;
        end
    end

    // cache codes go straight onto the bus, the encodings are identical
    assign attr_if.attr_rb = q[15:8];
    assign attr_if.share_out = q[7:6];
    assign attr_if.awcache = q[11:8];
    assign attr_if.arcache = q[3:0];

    AST_CACHE_FOLLOWS: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        trcfg_legal(attr_if.attr) |=> attr_if.awcache == $past(attr_if.attr[3:0]))
        else $error("write cache code does not follow a legal attribute");
    AST_NO_BAD_CACHE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        !trcfg_legal(attr_if.attr) |=> attr_if.attr_rb == trcfg_pkg::ATTR_SAFE)
        else $error("reserved attribute reached the bus");

endmodule : trcfg_attr_map

// ### design/trcfg_pkg.sv
// shared constants and the state type of the trace router configuration registers
package trcfg_pkg;

    // =====================================================================
    // register byte offsets
    localparam logic [11:0] OFS_STATUS = 12'h00c;
    localparam logic [11:0] OFS_CONTROL = 12'h020;
    localparam logic [11:0] OFS_OP_MODE = 12'h028;
    localparam logic [11:0] OFS_VACANCY_THRESHOLD = 12'h034;
    localparam logic [11:0] OFS_MEMORY_BUS_CONTROL = 12'h110;
    localparam logic [11:0] OFS_FORMAT_FLUSH_CTRL = 12'h304;
    localparam logic [11:0] OFS_SYNC_PERIOD = 12'h308;
    localparam logic [11:0] OFS_INTEGRATION_CTRL = 12'hf00;
    localparam logic [11:0] OFS_CLAIM_SET = 12'hfa0;
    localparam logic [11:0] OFS_CLAIM_CLEAR = 12'hfa4;
    localparam logic [11:0] OFS_DEBUG_PERMISSION_STATE = 12'hfb8;
    localparam logic [11:0] OFS_DEVICE_CONFIG = 12'hfc8;

    // =====================================================================
    // field positions
    localparam int BUFFER_FULL_FLAG_POS = 0;
    localparam int STS_IDLE_POS = 2;
    localparam int FF_FORMATTER_ENABLE = 0;
    localparam int FF_INSERT_FLUSH_MARKER = 1;
    localparam int FF_FLUSH_ON_FLUSH_INPUT = 4;
    localparam int FF_FLUSH_ON_TRIGGER_EVENT = 5;
    localparam int FF_MANUAL_FLUSH_REQUEST = 6;
    localparam int FF_MARK_ON_TRIGGER_INPUT = 8;
    localparam int FF_MARK_ON_TRIGGER_EVENT = 9;
    localparam int FF_MARK_ON_FLUSH_DONE = 10;
    localparam int FF_HALT_AFTER_FLUSH = 12;
    localparam int FF_HALT_AFTER_TRIGGER = 13;
    localparam logic [13:0] FF_WRITE_MASK = 14'h3773;
    localparam int BUS_SHARE_LSB = 20;
    localparam int BUS_ATTR_HI_LSB = 16;
    localparam int BUS_ATTR_LO_LSB = 2;
    localparam int AUTH_SPASSIVE_LSB = 6;
    localparam int AUTH_SACTIVE_LSB = 4;
    localparam int AUTH_NSPASSIVE_LSB = 2;
    localparam int AUTH_NSACTIVE_LSB = 0;
    localparam int DEV_NO_SCATTER_POS = 24;
    localparam int DEV_CACHE_TYPE_LSB = 16;
    localparam int DEV_MEM_WIDTH_LSB = 8;
    localparam int DEV_MODES_LSB = 4;

    // =====================================================================
    // reset values and fixed encodings
    localparam logic [4:0] SYNC_COUNT_RST = 5'h0a;
    localparam logic CAPTURE_IDLE_RST = 1'b1;
    localparam logic [1:0] AUTH_NOT_IMPL = 2'h0;
    localparam logic [1:0] AUTH_DISABLED = 2'h2;
    localparam logic [1:0] AUTH_ENABLED = 2'h3;
    localparam logic [1:0] MODE_CIRCULAR = 2'h0;
    localparam logic [2:0] MODES_NO_THRESHOLD = 3'h2;
    localparam logic [1:0] SHARE_NONE = 2'h0;
    localparam logic [1:0] SHARE_RESERVED = 2'h1;
    localparam logic [7:0] ATTR_SAFE = 8'h00;

    // =====================================================================
    // state of the register block, apart from the attribute mapper register and the check helper flags
    typedef struct packed {
        logic capture_enable;
        logic [1:0] op_mode;
        logic [13:0] ffcr;
        logic flush_pulse;
        logic [4:0] sync_count;
        logic integ_mode;
        logic [3:0] claim;
        logic [29:0] vacancy;
        logic [1:0] share;
        logic [3:0] attr_hi;
        logic [3:0] attr_lo;
        logic idle;
        logic full;
        logic [31:0] rdata;
        logic ack;
        logic sact_s1;
        logic sact_s2;
        logic nsact_s1;
        logic nsact_s2;
    } trcfg_state_t;

endpackage : trcfg_pkg

// ### design/trcfg_regs.sv
// trace router configuration registers: auth status, watermark, bus control
// What this block does
// - reset clears controls, sync count 10, idle set
// - secure passive debug field reads 00
// - secure active debug field reports 00/10/11
// - nonsecure passive debug field reads 00
// - nonsecure active debug field reports 00/10/11
// - nonsecure active debug preferably always enabled
// - permission register read-only, upper bits zero
// - full flag when free words at or below threshold
// - threshold ignored in circular mode
// - threshold register absent when modes equal 010
// - reserved bus fields act as implemented values
// - shareability field encodings 00, 10, 11
// - attribute assembled from bits 19:16 and 5:2
// - older bus: ten legal cache encodings
// - newer bus plain: eight legal encodings
// - newer bus split: twelve encodings, separate nibbles
// - unsupported attribute acts compatible, reads back as the safe code 00
// - attribute also covers scatter table accesses
// - attribute drives read and write cache codes
// - no scatter mode, indicator reads one
module trcfg_regs #(
    parameter logic [2:0] SUPPORTED_MODES = 3'h0,
    parameter logic [2:0] MEM_WIDTH = 3'h2,
    parameter logic [1:0] CACHE_TYPE = 2'h0,
    parameter bit BUS_AXI4 = 1'b0,
    parameter bit HAS_SWFIFO = 1'b0,
    parameter bit SACT_IMPL = 1'b1,
    parameter bit NSACT_IMPL = 1'b1,
    parameter bit NSACT_FORCE_ON = 1'b1
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // register port
    input wire logic i_reg_en,
    input wire logic i_reg_write,
    input wire logic [11:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    output logic o_reg_ack,
    // authentication pins
    input wire logic i_secure_active_dbg_en,
    input wire logic i_nonsecure_active_dbg_en,
    // datapath status
    input wire logic [31:0] i_free_words,
    // control out to the capture logic
    output logic o_capture_enable,
    output logic [1:0] o_op_mode,
    output logic [13:0] o_format_flush_ctrl,
    output logic o_manual_flush_pulse,
    output logic [4:0] o_periodic_sync_count,
    output logic o_integration_mode_on,
    output logic [3:0] o_claim_tags,
    output logic o_buffer_full_flag,
    output logic o_capture_idle_flag,
    // memory bus attributes
    output logic [3:0] o_awcache,
    output logic [3:0] o_arcache,
    output logic [1:0] o_buffer_share_domain
);

    // =====================================================================
    // state and attribute mapper
    trcfg_pkg::trcfg_state_t st;
    trcfg_pkg::trcfg_state_t next_st;
    trcfg_attr_if attr_if ();

    localparam bit HAS_THRESHOLD = (SUPPORTED_MODES != trcfg_pkg::MODES_NO_THRESHOLD);
    localparam bit NO_SCATTER = 1'b1; // scatter walking is not built

    // helpers: the answer in flight belongs to the permission register, or to the threshold register
    logic rd_auth_q;
    logic rd_thr_q;

    // field value of an active-debug permission
    function automatic logic [1:0] trcfg_auth(input logic impl, input logic en);
        logic [1:0] v;
        v = trcfg_pkg::AUTH_NOT_IMPL;
        if (impl) begin
            v = en ? trcfg_pkg::AUTH_ENABLED : trcfg_pkg::AUTH_DISABLED;
        end
        return v;
    endfunction : trcfg_auth

    // =====================================================================
    // next state
    always_comb begin
        logic [31:0] rd;
        logic [31:0] memory_bus_control;
        logic nsact_en;
        rd = 32'h0000_0000;
        memory_bus_control = 32'h0000_0000;
        nsact_en = NSACT_FORCE_ON | st.nsact_s2;
        next_st = st;
        // pins cross in through two flops; only the second is read
        next_st.sact_s1 = i_secure_active_dbg_en;
        next_st.sact_s2 = st.sact_s1;
        next_st.nsact_s1 = i_nonsecure_active_dbg_en;
        next_st.nsact_s2 = st.nsact_s1;
        // manual flush is a one-shot request that reads back as zero
        next_st.flush_pulse = 1'b0;
        next_st.ffcr[trcfg_pkg::FF_MANUAL_FLUSH_REQUEST] = 1'b0;
        // bus-facing view of the bus control register
        memory_bus_control[trcfg_pkg::BUS_SHARE_LSB +: 2] = attr_if.share_out;
        memory_bus_control[trcfg_pkg::BUS_ATTR_HI_LSB +: 4] = attr_if.attr_rb[7:4];
        memory_bus_control[trcfg_pkg::BUS_ATTR_LO_LSB +: 4] = attr_if.attr_rb[3:0];
        // writes
        if (i_reg_en && i_reg_write) begin
            case (i_reg_addr)
                trcfg_pkg::OFS_CONTROL: begin
                    next_st.capture_enable = i_reg_wdata[0];
                end
                trcfg_pkg::OFS_OP_MODE: begin
                    next_st.op_mode = i_reg_wdata[1:0];
                end
                trcfg_pkg::OFS_VACANCY_THRESHOLD: begin
                    // writes while enabled are accepted as is; software keeps to the
                    // disabled window and to the alignment
                    if (HAS_THRESHOLD) begin
                        next_st.vacancy = i_reg_wdata[29:0];
                    end
                end
                trcfg_pkg::OFS_MEMORY_BUS_CONTROL: begin
                    // taken at any time; only safe while disabled
                    next_st.share = i_reg_wdata[trcfg_pkg::BUS_SHARE_LSB +: 2];
                    next_st.attr_hi = i_reg_wdata[trcfg_pkg::BUS_ATTR_HI_LSB +: 4];
                    next_st.attr_lo = i_reg_wdata[trcfg_pkg::BUS_ATTR_LO_LSB +: 4];
                end
                trcfg_pkg::OFS_FORMAT_FLUSH_CTRL: begin
                    next_st.ffcr = i_reg_wdata[13:0] & trcfg_pkg::FF_WRITE_MASK;
                    next_st.flush_pulse = i_reg_wdata[trcfg_pkg::FF_MANUAL_FLUSH_REQUEST];
                    next_st.ffcr[trcfg_pkg::FF_MANUAL_FLUSH_REQUEST] = 1'b0;
                end
                trcfg_pkg::OFS_SYNC_PERIOD: begin
                    next_st.sync_count = i_reg_wdata[4:0];
                end
                trcfg_pkg::OFS_INTEGRATION_CTRL: begin
                    next_st.integ_mode = i_reg_wdata[0];
                end
                trcfg_pkg::OFS_CLAIM_SET: begin
                    next_st.claim = st.claim | i_reg_wdata[3:0];
                end
                trcfg_pkg::OFS_CLAIM_CLEAR: begin
                    next_st.claim = st.claim & ~i_reg_wdata[3:0];
                end
                default: begin
                    // permission and config registers ignore writes
                end
            endcase
        end
        // reads, answered on the next edge
        case (i_reg_addr)
            trcfg_pkg::OFS_STATUS: begin
                rd[trcfg_pkg::BUFFER_FULL_FLAG_POS] = st.full;
                rd[trcfg_pkg::STS_IDLE_POS] = st.idle;
            end
            trcfg_pkg::OFS_CONTROL: rd[0] = st.capture_enable;
            trcfg_pkg::OFS_OP_MODE: rd[1:0] = st.op_mode;
            trcfg_pkg::OFS_VACANCY_THRESHOLD: begin
                rd[29:0] = HAS_THRESHOLD ? st.vacancy : 30'h0;
            end
            trcfg_pkg::OFS_MEMORY_BUS_CONTROL: rd = memory_bus_control;
            trcfg_pkg::OFS_FORMAT_FLUSH_CTRL: rd[13:0] = st.ffcr;
            trcfg_pkg::OFS_SYNC_PERIOD: rd[4:0] = st.sync_count;
            trcfg_pkg::OFS_INTEGRATION_CTRL: rd[0] = st.integ_mode;
            trcfg_pkg::OFS_CLAIM_SET: rd[3:0] = 4'hf;
            trcfg_pkg::OFS_CLAIM_CLEAR: rd[3:0] = st.claim;
            trcfg_pkg::OFS_DEBUG_PERMISSION_STATE: begin
                // bits above 7 and both passive fields stay zero
                rd[trcfg_pkg::AUTH_SPASSIVE_LSB +: 2] = trcfg_pkg::AUTH_NOT_IMPL;
                rd[trcfg_pkg::AUTH_SACTIVE_LSB +: 2] = trcfg_auth(SACT_IMPL, st.sact_s2);
                rd[trcfg_pkg::AUTH_NSPASSIVE_LSB +: 2] = trcfg_pkg::AUTH_NOT_IMPL;
                rd[trcfg_pkg::AUTH_NSACTIVE_LSB +: 2] = trcfg_auth(NSACT_IMPL, nsact_en);
            end
            trcfg_pkg::OFS_DEVICE_CONFIG: begin
                rd[trcfg_pkg::DEV_NO_SCATTER_POS] = NO_SCATTER;
                rd[trcfg_pkg::DEV_CACHE_TYPE_LSB +: 2] = CACHE_TYPE;
                rd[trcfg_pkg::DEV_MEM_WIDTH_LSB +: 3] = MEM_WIDTH;
                rd[trcfg_pkg::DEV_MODES_LSB +: 3] = SUPPORTED_MODES;
            end
            default: rd = 32'h0000_0000; // unmapped reads as zero
        endcase
        next_st.ack = i_reg_en;
        next_st.rdata = (i_reg_en && !i_reg_write) ? rd : 32'h0000_0000;
        // full tracks free space every cycle, so it drops as soon as space
        // exceeds the threshold again
        next_st.full = HAS_THRESHOLD && (st.op_mode != trcfg_pkg::MODE_CIRCULAR) &&
            (i_free_words <= {2'h0, st.vacancy});
        next_st.idle = ~st.capture_enable;
    end

    // =====================================================================
    // state register with reset values
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '0; // controls, claim and bus fields cleared
            st.sync_count <= trcfg_pkg::SYNC_COUNT_RST;
            st.idle <= trcfg_pkg::CAPTURE_IDLE_RST;
        end else begin
            st <= next_st;
        end
    end

    // helper flags for the checks below
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_auth_q <= 1'b0;
            rd_thr_q <= 1'b0;
        end else begin
            rd_auth_q <= i_reg_en && !i_reg_write &&
                (i_reg_addr == trcfg_pkg::OFS_DEBUG_PERMISSION_STATE);
            rd_thr_q <= i_reg_en && !i_reg_write &&
                (i_reg_addr == trcfg_pkg::OFS_VACANCY_THRESHOLD);
        end
    end

    // =====================================================================
    // attribute mapping; with no scatter tables the same attribute is the
    // only one in use, so table accesses never need a second copy
    assign attr_if.attr = {st.attr_hi, st.attr_lo};
    assign attr_if.share = st.share;

    trcfg_attr_map #(
        .BUS_AXI4(BUS_AXI4),
        .HAS_SWFIFO(HAS_SWFIFO)
    ) u_attr_map (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .attr_if(attr_if)
    );

    // =====================================================================
    // outputs, each from a flop
    assign o_reg_rdata = st.rdata;
    assign o_reg_ack = st.ack;
    assign o_capture_enable = st.capture_enable;
    assign o_op_mode = st.op_mode;
    assign o_format_flush_ctrl = st.ffcr;
    assign o_manual_flush_pulse = st.flush_pulse;
    assign o_periodic_sync_count = st.sync_count;
    assign o_integration_mode_on = st.integ_mode;
    assign o_claim_tags = st.claim;
    assign o_buffer_full_flag = st.full;
    assign o_capture_idle_flag = st.idle;
    assign o_awcache = attr_if.awcache;
    assign o_arcache = attr_if.arcache;
    assign o_buffer_share_domain = attr_if.share_out;

    // =====================================================================
    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    AST_RESET_VALUES: assert property ($rose(i_resetn) |-> o_periodic_sync_count == 5'h0a
        && o_capture_idle_flag && !o_capture_enable && o_claim_tags == 4'h0)
        else $error("reset values wrong");
    AST_AUTH_PASSIVE_ZERO: assert property (rd_auth_q |-> o_reg_rdata[7:6] == 2'h0
        && o_reg_rdata[3:2] == 2'h0)
        else $error("passive debug field not zero");
    AST_AUTH_SECURE: assert property (rd_auth_q |-> o_reg_rdata[5:4] ==
        (SACT_IMPL ? {1'b1, $past(st.sact_s2)} : 2'h0))
        else $error("secure active debug field wrong");
    AST_AUTH_NONSECURE: assert property (rd_auth_q && NSACT_FORCE_ON && NSACT_IMPL
        |-> o_reg_rdata[1:0] == 2'h3)
        else $error("nonsecure active debug not reported enabled");
    AST_AUTH_UPPER: assert property (rd_auth_q |-> o_reg_rdata[31:8] == 24'h0)
        else $error("permission register upper bits not zero");
    AST_FULL_SET: assert property (HAS_THRESHOLD && st.op_mode != 2'h0
        && i_free_words <= {2'h0, st.vacancy} |=> o_buffer_full_flag)
        else $error("full flag missed");
    AST_CIRCULAR_NOT_FULL: assert property ((st.op_mode == 2'h0)[*2] |-> !o_buffer_full_flag)
        else $error("full flag raised in circular mode");
    AST_FULL_CLEAR: assert property (o_buffer_full_flag && i_free_words > {2'h0, st.vacancy}
        |=> !o_buffer_full_flag)
        else $error("full flag did not clear");
    AST_THRESHOLD_ABSENT: assert property (rd_thr_q && !HAS_THRESHOLD |-> o_reg_rdata == 32'h0)
        else $error("absent threshold register reads nonzero");
    AST_SHARE_LEGAL: assert property (o_buffer_share_domain != 2'h1)
        else $error("reserved shareability reached the bus");
    AST_ACK_TIMING: assert property (i_reg_en |=> o_reg_ack ##1 !o_reg_ack || $past(i_reg_en, 1))
        else $error("register answer not one cycle after request");

    COV_MEMORY_BUS_CONTROL_WRITE: cover property (i_reg_en && i_reg_write
        && i_reg_addr == trcfg_pkg::OFS_MEMORY_BUS_CONTROL);
    COV_FULL_RISE: cover property ($rose(o_buffer_full_flag));
    COV_AUTH_READ: cover property (rd_auth_q);
    COV_FLUSH: cover property (o_manual_flush_pulse);

endmodule : trcfg_regs

// ### tb/trace_router_config_regs_tb.sv
// self-checking bench for the trace router configuration registers
module trace_router_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // stimulus and observed signals
    logic clk = 1'b0, rstn = 1'b0, en = 1'b0, wr = 1'b0, sact = 1'b0, nsact = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, free = 32'h0, rd, rdata, w, rdata2;
    logic ack, cap, flush_p, integ, full, idle;
    logic [1:0] mode, share, s;
    logic [13:0] ffc;
    logic [4:0] sync;
    logic [3:0] claim, awc, arc;
    logic [7:0] a, ea;
    logic [29:0] wm;
    int error_cnt = 0, checks = 0;
    always #2.5 clk = ~clk;
    trcfg_regs u_dut (.i_ref_clk(clk), .i_resetn(rstn), .i_reg_en(en), .i_reg_write(wr),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
        .i_secure_active_dbg_en(sact), .i_nonsecure_active_dbg_en(nsact),
        .i_free_words(free), .o_capture_enable(cap), .o_op_mode(mode),
        .o_format_flush_ctrl(ffc), .o_manual_flush_pulse(flush_p),
        .o_periodic_sync_count(sync), .o_integration_mode_on(integ), .o_claim_tags(claim),
        .o_buffer_full_flag(full), .o_capture_idle_flag(idle), .o_awcache(awc),
        .o_arcache(arc), .o_buffer_share_domain(share));
    // a copy built without the threshold register; only its read data is watched
    trcfg_regs #(.SUPPORTED_MODES(3'h2)) u_dut_nothr (.i_ref_clk(clk), .i_resetn(rstn),
        .i_reg_en(en), .i_reg_write(wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata2), .o_reg_ack(), .i_secure_active_dbg_en(sact),
        .i_nonsecure_active_dbg_en(nsact), .i_free_words(free), .o_capture_enable(),
        .o_op_mode(), .o_format_flush_ctrl(), .o_manual_flush_pulse(),
        .o_periodic_sync_count(), .o_integration_mode_on(), .o_claim_tags(),
        .o_buffer_full_flag(), .o_capture_idle_flag(), .o_awcache(), .o_arcache(),
        .o_buffer_share_domain());
    // ==========================================================
    // checking and bus tasks
    task end_sim;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one access: request held for exactly the taking edge, answer sampled after it
    task acc(input logic wr_i, input logic [11:0] a_i, input logic [31:0] d_i);
        @(posedge clk);
        #1 en = 1'b1; wr = wr_i; addr = a_i; wdata = d_i;
        @(posedge clk);
        #1 en = 1'b0; wr = 1'b0;
        chk("ack", 32'h1, {31'h0, ack});
        rd = rdata;
    endtask : acc
    task rdchk(input string what, input logic [11:0] a_i, input logic [31:0] exp);
        acc(1'b0, a_i, 32'h0);
        chk(what, exp, rd);
    endtask : rdchk
    task chk_reset;
        chk("sync", 32'd10, {27'h0, sync});
        chk("outs", 32'h1, {8'h0, cap, mode, ffc, flush_p, integ, claim, idle});
        chk("bus outs", 32'h0, {21'h0, full, awc, arc, share});
        rdchk("ctl", trcfg_pkg::OFS_CONTROL, 32'h0);
        rdchk("ffcr", trcfg_pkg::OFS_FORMAT_FLUSH_CTRL, 32'h0);
        rdchk("syncr", trcfg_pkg::OFS_SYNC_PERIOD, 32'ha);
        rdchk("integ", trcfg_pkg::OFS_INTEGRATION_CTRL, 32'h0);
        rdchk("claim", trcfg_pkg::OFS_CLAIM_CLEAR, 32'h0);
        rdchk("memory_bus_control", trcfg_pkg::OFS_MEMORY_BUS_CONTROL, 32'h0);
        rdchk("status", trcfg_pkg::OFS_STATUS, 32'h4);
        $display("test reset done");
    endtask : chk_reset
    // legal cache codes of the older bus; anything else falls back to the safe code
    function automatic logic [7:0] exp_attr(input logic [7:0] v);
        case (v)
            8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h0a, 8'h0b, 8'h0e, 8'h0f: return v;
            default: return 8'h00;
        endcase
    endfunction : exp_attr
    function automatic logic exp_full(input logic [1:0] m, input logic [29:0] t,
        input logic [31:0] f);
        return (m != 2'h0) && (f <= {2'h0, t});
    endfunction : exp_full
    // ==========================================================
    // watchdog: the whole run needs only a few hundred cycles, far below the 20000-cycle limit
    initial begin
        #100us;
        error_cnt++;
        end_sim();
    end
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'hfa3f5fff));
        repeat (4) @(posedge clk);
        #1 rstn = 1'b1;
        chk_reset();
        for (int i = 0; i < 4; i++) begin
            sact = i[0];
            nsact = i[1];
            repeat (3) @(posedge clk);
            #1 w = {26'h0, i[0] ? 2'h3 : 2'h2, 4'h3};
            rdchk("perm", trcfg_pkg::OFS_DEBUG_PERMISSION_STATE, w);
        end
        acc(1'b1, trcfg_pkg::OFS_DEBUG_PERMISSION_STATE, 32'hffffffff);
        rdchk("perm ro", trcfg_pkg::OFS_DEBUG_PERMISSION_STATE, w);
        rdchk("unmapped", 12'h100, 32'h0);
        $display("test permission done");
        for (int i = 0; i < 24; i++) begin
            wm = (i == 0) ? 30'h0 : (i == 1) ? 30'h3ffffffe :
                30'($urandom()) & 30'h3ffffffe;
            s = (i < 3) ? i[1:0] : 2'($urandom_range(2, 0));
            acc(1'b1, trcfg_pkg::OFS_OP_MODE, {30'h0, s});
            chk("mode", {30'h0, s}, {30'h0, mode});
            acc(1'b1, trcfg_pkg::OFS_VACANCY_THRESHOLD, {2'h3, wm});
            rdchk("thresh", trcfg_pkg::OFS_VACANCY_THRESHOLD, {2'h0, wm});
            chk("thresh absent", 32'h0, rdata2);
            for (int k = 0; k < 4; k++) begin
                free = (k == 0) ? {2'h0, wm} : (k == 1) ? {2'h0, wm} + 32'h1 : (k == 2) ?
                    {2'h0, wm} - 32'h1 : $urandom();
                @(posedge clk);
                #1 chk("full", {31'h0, exp_full(s, wm, free)}, {31'h0, full});
            end
        end
        $display("test threshold done");
        for (int i = 0; i < 40; i++) begin
            a = (i < 16) ? {4'h0, 4'(i)} : 8'($urandom());
            s = 2'(i);
            w = $urandom();
            w[21:20] = s;
            w[19:16] = a[7:4];
            w[5:2] = a[3:0];
            acc(1'b1, trcfg_pkg::OFS_MEMORY_BUS_CONTROL, w);
            @(posedge clk);
            #1 ea = exp_attr(a);
            chk("awcache", {28'h0, ea[3:0]}, {28'h0, awc});
            chk("arcache", {28'h0, ea[3:0]}, {28'h0, arc});
            chk("share", {30'h0, s == 2'h1 ? 2'h0 : s}, {30'h0, share});
            rdchk("memory_bus_control", trcfg_pkg::OFS_MEMORY_BUS_CONTROL,
                {10'h0, s == 2'h1 ? 2'h0 : s, ea[7:4], 10'h0, ea[3:0], 2'h0});
        end
        acc(1'b0, trcfg_pkg::OFS_DEVICE_CONFIG, 32'h0);
        chk("no scatter", 32'h1, {31'h0, rd[24]});
        $display("test bus control done");
        for (int i = 0; i < 3; i++) begin
            w = $urandom() | (i == 0 ? 32'h40 : 32'h0);
            acc(1'b1, trcfg_pkg::OFS_FORMAT_FLUSH_CTRL, w);
            chk("flush pulse", {31'h0, w[6]}, {31'h0, flush_p});
            @(posedge clk);
            #1 chk("flush end", 32'h0, {31'h0, flush_p});
            chk("ffc", {18'h0, w[13:0] & trcfg_pkg::FF_WRITE_MASK & 14'h3fbf}, {18'h0, ffc});
        end
        $display("test flush done");
        // controls moved away from reset so the second reset has work to do
        w = $urandom();
        acc(1'b1, trcfg_pkg::OFS_CONTROL, 32'h1);
        acc(1'b1, trcfg_pkg::OFS_SYNC_PERIOD, w);
        acc(1'b1, trcfg_pkg::OFS_INTEGRATION_CTRL, 32'h1);
        acc(1'b1, trcfg_pkg::OFS_CLAIM_SET, w);
        acc(1'b1, trcfg_pkg::OFS_CLAIM_CLEAR, {28'h0, w[7:4]});
        chk("ctl outs", {20'h0, w[4:0], w[3:0] & ~w[7:4], 3'h6},
            {20'h0, sync, claim, integ, cap, idle});
        rdchk("claim set", trcfg_pkg::OFS_CLAIM_SET, 32'hf);
        $display("test controls done");
        @(posedge clk);
        #1 rstn = 1'b0;
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        chk_reset();
        end_sim();
    end
endmodule : trace_router_config_regs_tb
